//--- rtl/tmr_pkg.sv
// Constants for the PWM, one-pulse and encoder timer block
// Summary of operation
// - Up PWM1: reference high while counter below compare
// - Up PWM1: compare above reload high, zero low
// - Edge-aligned down PWM1: low above compare, else high
// - Direction bit low counts up, high down
// - Any nonzero alignment field selects center counting, except in encoder modes
// - Center flag on up, down or both matches
// - Hardware owns direction bit while center-aligned
// - Center counting starts in current direction
// - Counter write above reload keeps direction
// - Writing zero or reload updates direction, no update
// - Single-pulse bit stops counter at update event
// - Delay equals compare, pulse equals reload minus compare
// - Trigger mode with second input edge starts counter
// - Edge-aligned PWM2 counting up rises at match, falls at reload
// - Single-pulse trigger edge sets counter enable bit
// - Fast enable forces match level on trigger
// - Encoder codes select second, first or both inputs
// - Each valid selected transition clocks counter once
// - Direction recomputed on each single-input encoder transition, kept when both move
// - Encoder counter wraps between zero and reload
// - Quadrature direction follows opposite input level
// - Output codes 110 and 111 select PWM modes
// - Preloaded values move to active only on update
// - Reference active high, output inverted by polarity
package tmr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL_ONE  = 8'h00;
  localparam logic [7:0] OFS_SLAVE     = 8'h04;
  localparam logic [7:0] OFS_CHAN_CFG  = 8'h08;
  localparam logic [7:0] OFS_EVENT     = 8'h0c;
  localparam logic [7:0] OFS_COUNT     = 8'h10;
  localparam logic [7:0] OFS_RELOAD    = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_COMPARE0  = 8'h20;

  // ==========================================================
  // Field positions
  localparam int CTRL_CEN_BIT  = 0;
  localparam int CTRL_OPM_BIT  = 1;
  localparam int CTRL_DIR_BIT  = 2;
  localparam int CTRL_ALIGN_LO = 3;
  localparam int CTRL_ARPE_BIT = 5;
  localparam int SLAVE_TS_LO   = 4;
  localparam int CFG_IPOL_A    = 16;
  localparam int CFG_IPOL_B    = 17;
  localparam int CFG_CH_STRIDE = 6;
  localparam int CFG_PRE_BIT   = 3;
  localparam int CFG_FE_BIT    = 4;
  localparam int CFG_POL_BIT   = 5;
  localparam int STAT_UPD_BIT  = 8;

  // ==========================================================
  // Modes
  typedef enum logic [2:0] {
    OM_FROZEN  = 3'h0,
    OM_SET     = 3'h1,
    OM_CLEAR   = 3'h2,
    OM_TOGGLE  = 3'h3,
    OM_FLOW    = 3'h4,
    OM_FHIGH   = 3'h5,
    OM_PWM1    = 3'h6,
    OM_PWM2    = 3'h7
  } out_mode_e;

  localparam logic [2:0] SM_ENC_B    = 3'h1;
  localparam logic [2:0] SM_ENC_A    = 3'h2;
  localparam logic [2:0] SM_ENC_AB   = 3'h3;
  localparam logic [2:0] SM_TRIGGER  = 3'h6;
  localparam logic [2:0] TS_IN_A     = 3'h5;
  localparam logic [2:0] TS_IN_B     = 3'h6;
  localparam logic [1:0] ALIGN_EDGE  = 2'h0;
  localparam logic [1:0] ALIGN_DOWN  = 2'h1;
  localparam logic [1:0] ALIGN_UP    = 2'h2;

  // Reset values
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;

endpackage : tmr_pkg

//--- rtl/timer_pwm_enc.sv
// PWM, one-pulse and quadrature encoder timer with register port
`timescale 1ns/1ps
`default_nettype none

module timer_pwm_enc
  import tmr_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int NCH   = 2
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Encoder or trigger inputs
  input  wire logic              encoder_in_a,
  input  wire logic              encoder_in_b,
  // Channel and counter outputs
  output logic      [NCH-1:0]    chan_ref_wave,
  output logic      [NCH-1:0]    chan_out_pin,
  output logic      [CNT_W-1:0]  counter_value,
  output logic                   counter_running
);

  // ==========================================================
  // Configuration registers
  logic             single_pulse_bit_r;
  logic [1:0]       align_select_field_r;
  logic             reload_preload_bit_r;
  logic [2:0]       slave_mode_field_r;
  logic [2:0]       trigger_select_field_r;
  logic             in_pol_a_r;
  logic             in_pol_b_r;
  logic [2:0]       chan_output_mode_r [NCH];
  logic [NCH-1:0]   chan_compare_preload_r;
  logic [NCH-1:0]   chan_fast_enable_r;
  logic [NCH-1:0]   chan_polarity_bit_r;
  logic [CNT_W-1:0] auto_reload_value_r;
  logic [CNT_W-1:0] reload_shadow_r;
  logic [CNT_W-1:0] chan_compare_value_r [NCH];
  logic [CNT_W-1:0] compare_shadow_r [NCH];

  // Counter state
  logic             counter_enable_bit_r;
  logic             counter_enable_bit_nxt;
  logic             count_direction_bit_r;
  logic             count_direction_bit_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             update_event;
  logic             tick;

  // Status flags
  logic [NCH-1:0]   match_flag_r;
  logic [NCH-1:0]   match_set;
  logic             update_flag_r;

  // Input tracking
  logic             filtered_in_a;
  logic             filtered_in_b;
  logic             prev_a_r;
  logic             prev_b_r;
  logic             edge_a;
  logic             edge_b;
  logic             enc_up;
  logic             trigger_input;
  logic             trig_evt;

  logic             wr_ctrl;
  logic             wr_count;
  logic             force_update_bit;
  logic             center_mode;
  logic             enc_mode;
  logic [CNT_W-1:0] arr_act;
  logic [CNT_W-1:0] wr_cnt_val;

  assign wr_ctrl          = reg_wr && (reg_addr == OFS_CTRL_ONE);
  assign wr_count         = reg_wr && (reg_addr == OFS_COUNT);
  assign force_update_bit = reg_wr && (reg_addr == OFS_EVENT) && reg_wdata[0];
  assign wr_cnt_val       = reg_wdata[CNT_W-1:0];
  assign center_mode      = (align_select_field_r != ALIGN_EDGE);
  assign enc_mode         = (slave_mode_field_r == SM_ENC_A) ||
                            (slave_mode_field_r == SM_ENC_B) ||
                            (slave_mode_field_r == SM_ENC_AB);
  assign arr_act          = reload_preload_bit_r ? reload_shadow_r : auto_reload_value_r;

  // ==========================================================
  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      single_pulse_bit_r     <= 1'b0;
      align_select_field_r   <= ALIGN_EDGE;
      reload_preload_bit_r   <= 1'b0;
      slave_mode_field_r     <= 3'h0;
      trigger_select_field_r <= 3'h0;
      in_pol_a_r             <= 1'b0;
      in_pol_b_r             <= 1'b0;
      auto_reload_value_r    <= RST_ZERO[CNT_W-1:0];
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL_ONE: begin
          single_pulse_bit_r   <= reg_wdata[CTRL_OPM_BIT];
          align_select_field_r <= reg_wdata[CTRL_ALIGN_LO +: 2];
          reload_preload_bit_r <= reg_wdata[CTRL_ARPE_BIT];
        end
        OFS_SLAVE: begin
          slave_mode_field_r     <= reg_wdata[2:0];
          trigger_select_field_r <= reg_wdata[SLAVE_TS_LO +: 3];
        end
        OFS_CHAN_CFG: begin
          in_pol_a_r <= reg_wdata[CFG_IPOL_A];
          in_pol_b_r <= reg_wdata[CFG_IPOL_B];
        end
        OFS_RELOAD: auto_reload_value_r <= reg_wdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Input edges and trigger
  assign filtered_in_a = encoder_in_a ^ in_pol_a_r;
  assign filtered_in_b = encoder_in_b ^ in_pol_b_r;
  assign edge_a        = filtered_in_a ^ prev_a_r;
  assign edge_b        = filtered_in_b ^ prev_b_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_a_r <= 1'b0;
      prev_b_r <= 1'b0;
    end else begin
      prev_a_r <= filtered_in_a;
      prev_b_r <= filtered_in_b;
    end
  end

  // Quadrature direction from the input that moved and the level of the other
  always_comb begin
    if (edge_a) begin
      enc_up = filtered_in_a ^ filtered_in_b;
    end else begin
      enc_up = ~(filtered_in_a ^ filtered_in_b);
    end
  end

  always_comb begin
    unique case (trigger_select_field_r)
      TS_IN_A: trigger_input = filtered_in_a & edge_a;
      TS_IN_B: trigger_input = filtered_in_b & edge_b;
      default: trigger_input = 1'b0;
    endcase
  end

  assign trig_evt = (slave_mode_field_r == SM_TRIGGER) && trigger_input;

  // ==========================================================
  // Counter, direction and enable
  always_comb begin
    cnt_nxt                 = cnt_r;
    count_direction_bit_nxt = count_direction_bit_r;
    counter_enable_bit_nxt  = counter_enable_bit_r;
    update_event            = 1'b0;
    tick                    = 1'b0;
    if (enc_mode) begin
      // Both inputs moving at once carries no direction information
      if (edge_a ^ edge_b) begin
        count_direction_bit_nxt = ~enc_up;
      end
      tick = counter_enable_bit_r &&
             ((edge_a && !edge_b && slave_mode_field_r[1]) ||
              (edge_b && !edge_a && slave_mode_field_r[0]));
    end else begin
      tick = counter_enable_bit_r;
    end
    if (tick) begin
      if (center_mode && !enc_mode) begin
        if (!count_direction_bit_r) begin
          if (cnt_r >= arr_act) begin
            cnt_nxt                 = (arr_act == '0) ? '0 : arr_act - 1'b1;
            count_direction_bit_nxt = 1'b1;
            update_event            = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end else if (cnt_r == '0) begin
          cnt_nxt                 = (arr_act == '0) ? '0 : CNT_W'(1);
          count_direction_bit_nxt = 1'b0;
          update_event            = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end else if (!count_direction_bit_nxt) begin
        if (cnt_r >= arr_act) begin
          cnt_nxt      = '0;
          update_event = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end else if (cnt_r == '0 || cnt_r > arr_act) begin
        cnt_nxt      = arr_act;
        update_event = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
    if (force_update_bit) begin
      cnt_nxt      = (count_direction_bit_nxt && !center_mode) ? arr_act : '0;
      update_event = 1'b1;
    end
    if (wr_ctrl) begin
      counter_enable_bit_nxt = reg_wdata[CTRL_CEN_BIT];
      // Software may only steer direction in plain edge-aligned counting
      if (!center_mode && !enc_mode) begin
        count_direction_bit_nxt = reg_wdata[CTRL_DIR_BIT];
      end
    end
    if (wr_count) begin
      cnt_nxt = wr_cnt_val;
      if (center_mode) begin
        if (wr_cnt_val == '0) begin
          count_direction_bit_nxt = 1'b0;
        end else if (wr_cnt_val == arr_act) begin
          count_direction_bit_nxt = 1'b1;
        end
        // Values above reload leave the direction alone
      end
    end
    if (update_event && single_pulse_bit_r) begin
      counter_enable_bit_nxt = 1'b0;
    end
    if (trig_evt) begin
      counter_enable_bit_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r                 <= '0;
      count_direction_bit_r <= 1'b0;
      counter_enable_bit_r  <= 1'b0;
    end else begin
      cnt_r                 <= cnt_nxt;
      count_direction_bit_r <= count_direction_bit_nxt;
      counter_enable_bit_r  <= counter_enable_bit_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reload_shadow_r <= '0;
    end else if (update_event) begin
      reload_shadow_r <= auto_reload_value_r;
    end
  end

  // ==========================================================
  // Channels
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    logic [CNT_W-1:0] ccr_act;
    logic             hit;
    logic             cmp_lvl;
    logic             ref_nxt;
    logic             fast_hold_r;
    logic             match_lvl;
    logic             is_pwm;
    logic             flag_dir_ok;

    assign ccr_act   = chan_compare_preload_r[c] ? compare_shadow_r[c]
                                                 : chan_compare_value_r[c];
    assign hit       = tick && (cnt_nxt == ccr_act);
    assign is_pwm    = chan_output_mode_r[c][2] && chan_output_mode_r[c][1];
    // PWM1 leaves active at a match when counting up, PWM2 enters it
    assign match_lvl = chan_output_mode_r[c][0] ^ count_direction_bit_nxt;
    assign flag_dir_ok = !center_mode ||
                         (align_select_field_r == ALIGN_DOWN &&  count_direction_bit_nxt) ||
                         (align_select_field_r == ALIGN_UP   && !count_direction_bit_nxt) ||
                         (align_select_field_r == 2'h3);
    assign match_set[c] = hit && flag_dir_ok;

    always_comb begin
      if (count_direction_bit_nxt && !center_mode) begin
        cmp_lvl = (cnt_nxt <= ccr_act);
      end else begin
        cmp_lvl = (cnt_nxt < ccr_act);
      end
    end

    always_comb begin
      ref_nxt = chan_ref_wave[c];
      unique case (out_mode_e'(chan_output_mode_r[c]))
        OM_FROZEN: ref_nxt = chan_ref_wave[c];
        OM_SET:    ref_nxt = hit ? 1'b1 : chan_ref_wave[c];
        OM_CLEAR:  ref_nxt = hit ? 1'b0 : chan_ref_wave[c];
        OM_TOGGLE: ref_nxt = hit ? ~chan_ref_wave[c] : chan_ref_wave[c];
        OM_FLOW:   ref_nxt = 1'b0;
        OM_FHIGH:  ref_nxt = 1'b1;
        OM_PWM1:   ref_nxt = cmp_lvl;
        // Edge-aligned up-counting PWM2 drops as the count reaches reload: pulse is reload minus compare
        OM_PWM2:   ref_nxt = ~cmp_lvl && !(!count_direction_bit_nxt && !center_mode &&
                                           cnt_nxt == arr_act);
      endcase
      // Fast path bypasses the several cycles the compare needs after a trigger
      if (is_pwm && chan_fast_enable_r[c] && (trig_evt || fast_hold_r)) begin
        ref_nxt = match_lvl;
      end
    end

    // The forced level holds until the compare catches up
    always_ff @(posedge clk) begin
      if (rst) begin
        fast_hold_r <= 1'b0;
      end else if (hit || update_event) begin
        fast_hold_r <= 1'b0;
      end else if (trig_evt && is_pwm && chan_fast_enable_r[c]) begin
        fast_hold_r <= 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        chan_ref_wave[c] <= 1'b0;
        chan_out_pin[c]  <= 1'b0;
      end else begin
        chan_ref_wave[c] <= ref_nxt;
        chan_out_pin[c]  <= ref_nxt ^ chan_polarity_bit_r[c];
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        chan_output_mode_r[c]     <= OM_FROZEN;
        chan_compare_preload_r[c] <= 1'b0;
        chan_fast_enable_r[c]     <= 1'b0;
        chan_polarity_bit_r[c]    <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_CHAN_CFG) begin
        chan_output_mode_r[c]     <= reg_wdata[c*CFG_CH_STRIDE +: 3];
        chan_compare_preload_r[c] <= reg_wdata[c*CFG_CH_STRIDE + CFG_PRE_BIT];
        chan_fast_enable_r[c]     <= reg_wdata[c*CFG_CH_STRIDE + CFG_FE_BIT];
        chan_polarity_bit_r[c]    <= reg_wdata[c*CFG_CH_STRIDE + CFG_POL_BIT];
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        chan_compare_value_r[c] <= '0;
        compare_shadow_r[c]     <= '0;
      end else begin
        if (reg_wr && reg_addr == OFS_COMPARE0 + 8'(4 * c)) begin
          chan_compare_value_r[c] <= reg_wdata[CNT_W-1:0];
        end
        if (update_event) begin
          compare_shadow_r[c] <= chan_compare_value_r[c];
        end
      end
    end
  end

  // ==========================================================
  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      match_flag_r  <= '0;
      update_flag_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_STATUS) begin
        match_flag_r  <= (match_flag_r & ~reg_wdata[NCH-1:0]) | match_set;
        update_flag_r <= (update_flag_r & ~reg_wdata[STAT_UPD_BIT]) | update_event;
      end else begin
        match_flag_r  <= match_flag_r | match_set;
        update_flag_r <= update_flag_r | update_event;
      end
    end
  end

  // ==========================================================
  // Read port and status outputs
  logic [31:0] rd_mux;
  logic [31:0] cfg_word;

  always_comb begin
    cfg_word             = '0;
    cfg_word[CFG_IPOL_A] = in_pol_a_r;
    cfg_word[CFG_IPOL_B] = in_pol_b_r;
    for (int i = 0; i < NCH; i++) begin
      cfg_word[i*CFG_CH_STRIDE +: 3]           = chan_output_mode_r[i];
      cfg_word[i*CFG_CH_STRIDE + CFG_PRE_BIT]  = chan_compare_preload_r[i];
      cfg_word[i*CFG_CH_STRIDE + CFG_FE_BIT]   = chan_fast_enable_r[i];
      cfg_word[i*CFG_CH_STRIDE + CFG_POL_BIT]  = chan_polarity_bit_r[i];
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      OFS_CTRL_ONE: begin
        rd_mux[CTRL_CEN_BIT]       = counter_enable_bit_r;
        rd_mux[CTRL_OPM_BIT]       = single_pulse_bit_r;
        rd_mux[CTRL_DIR_BIT]       = count_direction_bit_r;
        rd_mux[CTRL_ALIGN_LO +: 2] = align_select_field_r;
        rd_mux[CTRL_ARPE_BIT]      = reload_preload_bit_r;
      end
      OFS_SLAVE: begin
        rd_mux[2:0]               = slave_mode_field_r;
        rd_mux[SLAVE_TS_LO +: 3]  = trigger_select_field_r;
      end
      OFS_CHAN_CFG: rd_mux = cfg_word;
      OFS_COUNT:    rd_mux[CNT_W-1:0] = cnt_r;
      OFS_RELOAD:   rd_mux[CNT_W-1:0] = auto_reload_value_r;
      OFS_STATUS: begin
        rd_mux[NCH-1:0]      = match_flag_r;
        rd_mux[STAT_UPD_BIT] = update_flag_r;
      end
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (reg_addr == OFS_COMPARE0 + 8'(4 * i)) begin
            rd_mux[CNT_W-1:0] = chan_compare_value_r[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata       <= '0;
      counter_value   <= '0;
      counter_running <= 1'b0;
    end else begin
      reg_rdata       <= reg_rd ? rd_mux : '0;
      counter_value   <= cnt_nxt;
      counter_running <= counter_enable_bit_nxt;
    end
  end

endmodule : timer_pwm_enc

`default_nettype wire

//--- tb/timer_pwm_enc_checker.sv
// Port-level assertions for the PWM, one-pulse and encoder timer
`timescale 1ns/1ps
`default_nettype none

module timer_pwm_enc_checker
  import tmr_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int NCH   = 2
) (
  // Clock and reset
  input wire logic             clk,
  input wire logic             rst,
  // Register port
  input wire logic [7:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [31:0]      reg_rdata,
  // Encoder inputs
  input wire logic             encoder_in_a,
  input wire logic             encoder_in_b,
  // Outputs
  input wire logic [NCH-1:0]   chan_ref_wave,
  input wire logic [NCH-1:0]   chan_out_pin,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic             counter_running
);
  logic [CNT_W-1:0] wr_count;
  logic [NCH-1:0]   pol_mix;
  logic             cfg_wr;
  assign wr_count = reg_wdata[CNT_W-1:0];
  assign pol_mix  = chan_out_pin ^ chan_ref_wave;
  assign cfg_wr   = reg_wr && (reg_addr == OFS_CHAN_CFG);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Assertions
  a_out_polarity: assert property (
    !$past(rst) && !$past(cfg_wr) && !$past(cfg_wr, 2) |-> $stable(pol_mix))
    else $error("output polarity moved without a config write");
  a_hold_stopped: assert property (
    !$past(rst) && !$past(counter_running) && !$past(reg_wr) |-> $stable(counter_value))
    else $error("stopped counter moved");
  a_step_size: assert property (
    !$past(rst) && $past(counter_running) && !$past(reg_wr) && $changed(counter_value)
    |-> counter_value == $past(counter_value) + 1'b1
     || counter_value == $past(counter_value) - 1'b1
     || counter_value == '0 || $past(counter_value) == '0)
    else $error("counter jumped");
  a_start_cause: assert property (
    $rose(counter_running) |-> $past(reg_wr)
      || $past(encoder_in_a) != $past(encoder_in_a, 2)
      || $past(encoder_in_b) != $past(encoder_in_b, 2))
    else $error("counter started without cause");
  a_trig_latency: assert property (
    $rose(counter_running) && !$past(reg_wr) |-> $stable(counter_value))
    else $error("counter moved in the start cycle");
  a_stop_update: assert property (
    $fell(counter_running) && !$past(reg_wr)
    |-> counter_value == '0 || $past(counter_value) == '0)
    else $error("counter stopped away from the update point");
  a_ref_cause: assert property (
    !$past(rst) && $changed(chan_ref_wave) && !$past(reg_wr) && !$past(reg_wr, 2)
    |-> $changed(counter_value) || $rose(counter_running))
    else $error("reference moved without a counter step");
  a_count_load: assert property (
    !$past(rst) && $past(reg_wr) && $past(reg_addr) == OFS_COUNT
    && !$past(counter_running) |-> counter_value == $past(wr_count))
    else $error("counter write not loaded");
endmodule : timer_pwm_enc_checker

bind timer_pwm_enc timer_pwm_enc_checker #(.CNT_W(CNT_W), .NCH(NCH)) chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .encoder_in_a(encoder_in_a),
  .encoder_in_b(encoder_in_b), .chan_ref_wave(chan_ref_wave), .chan_out_pin(chan_out_pin),
  .counter_value(counter_value), .counter_running(counter_running));

`default_nettype wire

//--- tb/enc_source.sv
// Quadrature encoder and trigger source facing the timer inputs
`timescale 1ns/1ps
`default_nettype none

module enc_source (
  // Clock
  input  wire logic clk,
  // Encoder lines
  output logic      enc_a,
  output logic      enc_b
);
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
  end

  // A real encoder moves one line per step; both at once is a deliberate fault
  task automatic move(input logic ta, input logic tb);
    @(posedge clk);
    enc_a <= enc_a ^ ta;
    enc_b <= enc_b ^ tb;
  endtask : move
endmodule : enc_source

`default_nettype wire

//--- tb/timer_pwm_pulse_encoder_modes_test.sv
// Self-checking bench for the PWM, one-pulse and encoder timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end

module timer_pwm_pulse_encoder_modes_test;
  import tmr_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [15:0] RLD = 16'h8;
  logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
  logic [1:0]  ref_w, out_w;
  logic [15:0] cnt, prev, cc;
  logic [2:0]  m;
  logic        run, dn, up, go, sel;
  wire logic   ina, inb;
  int          bad_count = 0, compares = 0, hi, lo;

  always #2 clk = ~clk;

  timer_pwm_enc DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .encoder_in_a(ina),
    .encoder_in_b(inb), .chan_ref_wave(ref_w), .chan_out_pin(out_w),
    .counter_value(cnt), .counter_running(run));
  enc_source src (.clk(clk), .enc_a(ina), .enc_b(inb));

  // ==========================================================
  // Bus tasks and models
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdc

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  function automatic logic exp_ref(logic [2:0] md, logic d, logic [15:0] c, logic [15:0] k);
    logic lvl;
    lvl = d ? (c <= k) : (c < k);
    return (md == OM_PWM2) ? (!lvl && (d || c != RLD)) : lvl;
  endfunction : exp_ref

  function automatic logic [15:0] nxt(logic d, logic [15:0] c);
    return d ? ((c == 16'h0) ? RLD : c - 16'h1) : ((c >= RLD) ? 16'h0 : c + 16'h1);
  endfunction : nxt

  task automatic results;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // ==========================================================
  // Tests
  initial begin
    void'($urandom(70));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr(8'hfc, 32'hffff_ffff);
    rdc(OFS_RELOAD);
    `CHK(rd, RST_ZERO)
    rdc(8'hfc);
    `CHK(rd, 32'h0)
    tick();
    `CHK(reg_rdata, 32'h0)
    // Edge PWM in both PWM modes and both directions
    for (int k = 0; k < 4; k++) begin
      m  = k[1] ? OM_PWM2 : OM_PWM1;
      dn = k[0];
      cc = 16'($urandom_range(8, 1));
      wr(OFS_CTRL_ONE, 32'h0);
      wr(OFS_CHAN_CFG, 32'h0);
      wr(OFS_RELOAD, 32'(RLD));
      wr(OFS_COMPARE0, 32'(cc));
      wr(OFS_COMPARE0 + 8'h4, (k == 0) ? 32'h0 : 32'h9);
      wr(OFS_CHAN_CFG, 32'(m) | (32'(m) << 6) | 32'h800);
      wr(OFS_CTRL_ONE, 32'h1 | (32'(dn) << 2));
      tick();
      prev = cnt;
      repeat (20) begin
        tick();
        `CHK(cnt, nxt(dn, prev))
        `CHK(ref_w[0], exp_ref(m, dn, cnt, cc))
        `CHK(ref_w[1], exp_ref(m, dn, cnt, (k == 0) ? 16'h0 : 16'h9))
        `CHK(out_w[1], ~ref_w[1])
        prev = cnt;
      end
    end
    // Center counting; the direction bit in the stop write must be ignored
    wr(OFS_CTRL_ONE, 32'h0);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_COMPARE0, 32'h4);
    wr(OFS_STATUS, 32'h1ff);
    wr(OFS_CTRL_ONE, 32'h9);
    repeat (4) tick();
    wr(OFS_CTRL_ONE, 32'hc);
    rdc(OFS_STATUS);
    `CHK(rd[0], 1'b0)
    rdc(OFS_CTRL_ONE);
    if (cnt < RLD) `CHK(rd[2], 1'b0)
    dn = rd[2];
    wr(OFS_CTRL_ONE, 32'h9);
    #1 prev = cnt;
    repeat (14) begin
      tick();
      if (!dn && prev == RLD) dn = 1'b1;
      else if (dn && prev == 16'h0) dn = 1'b0;
      `CHK(cnt, dn ? prev - 16'h1 : prev + 16'h1)
      prev = cnt;
    end
    rdc(OFS_STATUS);
    `CHK(rd[0], 1'b1)
    rdc(OFS_CTRL_ONE);
    `CHK(rd[2], dn)
    // Single pulse started by a rising edge on input B, channel 1 fast
    wr(OFS_CTRL_ONE, 32'h0);
    wr(OFS_CHAN_CFG, 32'h0);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_COMPARE0, 32'h3);
    wr(OFS_COMPARE0 + 8'h4, 32'h3);
    wr(OFS_CHAN_CFG, 32'h7 | 32'h1c0 | 32'h400);
    wr(OFS_SLAVE, {25'h0, TS_IN_B, 1'b0, SM_TRIGGER});
    wr(OFS_CTRL_ONE, 32'h2);
    src.move(1'b0, 1'b1);
    hi = 0;
    lo = 0;
    go = 1'b0;
    repeat (40) begin
      tick();
      if (run && !go) `CHK(ref_w, 2'b10)
      go = go | run;
      if (run && ref_w[0]) hi++;
      else if (run && hi == 0) lo++;
    end
    `CHK(go, 1'b1)
    `CHK(hi, 5)
    `CHK(lo, 3)
    `CHK({run, cnt}, 17'h0)
    // Encoder counting on B, A and both, random steps then a double step
    // Channels frozen: a direction flip alone would move a PWM level
    wr(OFS_CHAN_CFG, 32'h0);
    for (int s = 1; s < 4; s++) begin
      wr(OFS_CTRL_ONE, 32'h0);
      wr(OFS_SLAVE, 32'(s));
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CTRL_ONE, 32'h1);
      prev = 16'h0;
      repeat (12) begin
        sel = 1'($urandom_range(1, 0));
        up  = sel ^ ina ^ inb;
        src.move(sel, !sel);
        if (sel ? s[1] : s[0]) prev = nxt(!up, prev);
        tick();
        tick();
        `CHK(cnt, prev)
        rdc(OFS_CTRL_ONE);
        `CHK(rd[2], !up)
      end
      src.move(1'b1, 1'b1);
      tick();
      tick();
      `CHK(cnt, prev)
      rdc(OFS_CTRL_ONE);
      `CHK(rd[2], !up)
    end
    // Preloaded compare waits for an update event
    wr(OFS_SLAVE, 32'h0);
    wr(OFS_CTRL_ONE, 32'h0);
    wr(OFS_CHAN_CFG, 32'he);
    wr(OFS_COMPARE0, 32'h5);
    wr(OFS_COUNT, 32'h4);
    tick();
    `CHK(ref_w[0], 1'b0)
    wr(OFS_EVENT, 32'h1);
    wr(OFS_COUNT, 32'h4);
    tick();
    `CHK(ref_w[0], 1'b1)
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule : timer_pwm_pulse_encoder_modes_test

`default_nettype wire
